// >>> shared/conv_cfg_defines.svh
// Offsets, field positions, reset values and timing counts for the register bank
`ifndef CONV_CFG_DEFINES_SVH
`define CONV_CFG_DEFINES_SVH
`define OFS_SETPOINT 8'h00
`define OFS_CFG_A 8'h01
`define OFS_CFG_B 8'h02
`define OFS_CFG_C 8'h03
`define OFS_FLAGS 8'h04
`define RST_CFG_A 8'h2A
`define RST_CFG_B 8'h09
`define RST_CFG_C 8'h00
`define RST_FLAGS 8'h02
`define BIT_SOFT_RESET 7
`define BIT_SPREAD 6
`define BIT_SWITCH 5
`define BIT_FPWM 4
`define BIT_DISCH 3
`define BIT_HICCUP 2
`define BIT_SINGLE 1
`define BIT_PG_BLANK 0
`define MASK_CFG_B 8'h0F
`define MASK_CFG_C 8'h03
`define MASK_FLAGS 8'h3F
`define SETPOINT_STRAP_LOW 8'h00
`define SETPOINT_STRAP_HIGH 8'h50
`define APB_REG_CMD 12'h000
`define APB_REG_WDATA 12'h004
`define APB_REG_RDATA 12'h008
`define APB_REG_STATUS 12'h00C
`define TARGET_ADDR 7'h40
`define LINK_HALF_DIV 8'd4
`endif

// >>> shared/conv_cfg_pkg.sv
// Types shared by both ends of the configuration link
package conv_cfg_pkg;
  typedef enum logic [6:0] {
    S_IDLE = 7'h01, S_START = 7'h02, S_BYTE = 7'h04, S_ACK = 7'h08,
    S_STOP = 7'h10, S_DONE = 7'h20, S_RBYTE = 7'h40
  } host_state_t;
  typedef logic [7:0] byte_t;
endpackage : conv_cfg_pkg

// >>> shared/conv_link_if.sv
// Two-wire link between the controller end and the converter end
`timescale 1ns/1ps
interface conv_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  wire logic scl;
  wire logic sda;
  assign scl = scl_oe ? scl_o : 1'b1;
  assign sda = (sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o) ?
    1'b0 : 1'b1;
  modport host (output scl_o, scl_oe, sda_host_o, sda_host_oe,
    input scl, sda);
  modport device (output sda_dev_o, sda_dev_oe, input scl, sda);
endinterface : conv_link_if

// >>> verilog/conv_cfg_device.sv
// Converter register bank behind a two-wire target port
`timescale 1ns/1ps
`include "conv_cfg_defines.svh"
module conv_cfg_device
  import conv_cfg_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link
  conv_link_if.device link,
  // Straps and pins
  input wire logic start_voltage_strap_pin,
  input wire logic mode_sync_pin,
  input wire logic pg_window_ok,
  input wire logic dvs_active_in,
  input wire logic [5:0] fault_events,
  // Converter controls
  output logic [7:0] output_setpoint_code,
  output logic [15:0] setpoint_millivolt_x100,
  output logic spread_clock_enable,
  output logic switching_enable,
  output logic forced_pwm_active,
  output logic output_discharge_enable,
  output logic hiccup_enable,
  output logic [1:0] setpoint_slew_select,
  output logic [1:0] voltage_range_select,
  output logic [1:0] softstart_time_select,
  output logic single_mode,
  output logic en_pulldown_enable,
  output logic sync_clock_out_enable,
  output logic power_good_pin_o,
  output logic power_good_pin_oe
);
  logic [1:0] scl_sync_ff, sda_sync_ff, mode_sync_ff;
  logic scl_d_ff, sda_d_ff;
  logic [7:0] setpoint_ff, cfg_a_ff, cfg_b_ff, cfg_c_ff, flags_ff;
  logic strap_taken_ff, strap_ff;
  logic active_ff, addr_ok_ff, rd_ff, got_ptr_ff, ack_phase_ff;
  logic drive_low_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff, ptr_ff;
  logic wr_pend_ff, soft_rst_ff;
  logic [7:0] wr_data_ff;
  logic [1:0] strap_sync_ff, win_sync_ff, dvs_sync_ff;
  logic [5:0] ev_meta_ff, ev_sync_ff;

  wire scl_s = scl_sync_ff[1];
  wire sda_s = sda_sync_ff[1];
  wire scl_rise = scl_s && !scl_d_ff;
  wire scl_fall = !scl_s && scl_d_ff;
  wire start_c = scl_s && scl_d_ff && sda_d_ff && !sda_s;
  wire stop_c = scl_s && scl_d_ff && !sda_d_ff && sda_s;

  function automatic logic [7:0] read_reg(input logic [7:0] ofs);
    unique case (ofs)
      `OFS_SETPOINT: read_reg = setpoint_ff;
      `OFS_CFG_A: read_reg = cfg_a_ff & 8'h7F;
      `OFS_CFG_B: read_reg = cfg_b_ff & `MASK_CFG_B;
      `OFS_CFG_C: read_reg = cfg_c_ff & `MASK_CFG_C;
      `OFS_FLAGS: read_reg = flags_ff & `MASK_FLAGS;
      default: read_reg = 8'h00;
    endcase
  endfunction : read_reg

  wire [7:0] rd_byte = read_reg(ptr_ff);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sync_ff <= 2'b11;
      sda_sync_ff <= 2'b11;
      mode_sync_ff <= 2'b00;
      win_sync_ff <= 2'b11;
      dvs_sync_ff <= 2'b00;
      ev_meta_ff <= 6'h00;
      ev_sync_ff <= 6'h00;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], link.scl};
      sda_sync_ff <= {sda_sync_ff[0], link.sda};
      mode_sync_ff <= {mode_sync_ff[0], mode_sync_pin};
      win_sync_ff <= {win_sync_ff[0], pg_window_ok};
      dvs_sync_ff <= {dvs_sync_ff[0], dvs_active_in};
      ev_meta_ff <= fault_events;
      ev_sync_ff <= ev_meta_ff;
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  // No reset: the chain fills while reset is held
  always_ff @(posedge pclk) begin
    strap_sync_ff <= {strap_sync_ff[0], start_voltage_strap_pin};
  end

  // Strap caught once after release, not under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_taken_ff <= 1'b0;
      strap_ff <= 1'b0;
    end else if (!strap_taken_ff) begin
      strap_taken_ff <= 1'b1;
      strap_ff <= strap_sync_ff[1];
    end
  end

  // Link protocol engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_ff <= 1'b0;
      addr_ok_ff <= 1'b0;
      rd_ff <= 1'b0;
      got_ptr_ff <= 1'b0;
      ack_phase_ff <= 1'b0;
      drive_low_ff <= 1'b0;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      ptr_ff <= 8'h00;
      wr_pend_ff <= 1'b0;
      wr_data_ff <= 8'h00;
    end else begin
      if (start_c) begin
        active_ff <= 1'b1;
        addr_ok_ff <= 1'b0;
        got_ptr_ff <= 1'b0;
        ack_phase_ff <= 1'b0;
        bit_cnt_ff <= 4'h0;
        drive_low_ff <= 1'b0;
      end else if (stop_c) begin
        active_ff <= 1'b0;
        drive_low_ff <= 1'b0;
      end else if (active_ff && scl_rise && !ack_phase_ff) begin
        // Reads shift on the falling edge only
        if (!(rd_ff && addr_ok_ff)) begin
          shift_ff <= {shift_ff[6:0], sda_s};
        end
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end else if (active_ff && scl_rise && ack_phase_ff && rd_ff &&
                   addr_ok_ff && sda_s) begin
        active_ff <= 1'b0; // Controller nacked: stop sending
      end else if (active_ff && scl_fall) begin
        if (ack_phase_ff) begin
          ack_phase_ff <= 1'b0;
          drive_low_ff <= 1'b0;
          bit_cnt_ff <= 4'h0;
          if (wr_pend_ff) begin
            wr_pend_ff <= 1'b0;
          end
          if (rd_ff && addr_ok_ff) begin
            shift_ff <= rd_byte;
            drive_low_ff <= !rd_byte[7];
            ptr_ff <= ptr_ff + 8'h01;
          end
        end else if (bit_cnt_ff == 4'h8) begin
          ack_phase_ff <= 1'b1;
          if (!addr_ok_ff) begin
            addr_ok_ff <= (shift_ff[7:1] == `TARGET_ADDR);
            rd_ff <= shift_ff[0];
            drive_low_ff <= (shift_ff[7:1] == `TARGET_ADDR);
          end else if (!rd_ff) begin
            drive_low_ff <= 1'b1;
            if (!got_ptr_ff) begin
              got_ptr_ff <= 1'b1;
              ptr_ff <= shift_ff;
            end else begin
              wr_pend_ff <= 1'b1;
              wr_data_ff <= shift_ff;
            end
          end else begin
            drive_low_ff <= 1'b0;
          end
        end else if (rd_ff && addr_ok_ff) begin
          drive_low_ff <= !shift_ff[6];
          shift_ff <= {shift_ff[6:0], 1'b0};
        end
      end
    end
  end

  // Commit happens at ack falling edge; the pointer does not advance on writes
  wire commit = active_ff && scl_fall && ack_phase_ff && wr_pend_ff;
  // Clear at the edge the flags are loaded, so no event slips between
  wire flag_clear = active_ff && scl_fall && ack_phase_ff && rd_ff &&
    addr_ok_ff && (ptr_ff == `OFS_FLAGS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_a_ff <= `RST_CFG_A;
      cfg_b_ff <= `RST_CFG_B;
      cfg_c_ff <= `RST_CFG_C;
      setpoint_ff <= `SETPOINT_STRAP_LOW;
      soft_rst_ff <= 1'b0;
    end else if (soft_rst_ff || !strap_taken_ff) begin
      cfg_a_ff <= `RST_CFG_A;
      cfg_b_ff <= `RST_CFG_B;
      cfg_c_ff <= `RST_CFG_C;
      setpoint_ff <= (strap_taken_ff ? strap_ff : strap_sync_ff[1]) ?
        `SETPOINT_STRAP_HIGH : `SETPOINT_STRAP_LOW;
      soft_rst_ff <= 1'b0;
    end else if (commit) begin
      unique case (ptr_ff)
        `OFS_SETPOINT: setpoint_ff <= wr_data_ff;
        `OFS_CFG_A: begin
          cfg_a_ff <= {1'b0, wr_data_ff[6:0]};
          soft_rst_ff <= wr_data_ff[`BIT_SOFT_RESET];
        end
        `OFS_CFG_B: cfg_b_ff <= wr_data_ff & `MASK_CFG_B;
        `OFS_CFG_C: cfg_c_ff <= wr_data_ff & `MASK_CFG_C;
        default: ;
      endcase
    end
  end

  // Event set wins over read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= `RST_FLAGS;
    end else if (soft_rst_ff) begin
      flags_ff <= `RST_FLAGS | {2'b00, ev_sync_ff};
    end else begin
      flags_ff <= ((flag_clear ? 8'h00 : flags_ff) |
        {2'b00, ev_sync_ff}) & `MASK_FLAGS;
    end
  end

  // Setpoint in units of 10 uV
  function automatic logic [15:0] setpoint_x100(input logic [7:0] code,
                                                input logic [1:0] rng);
    unique case (rng)
      2'b00: setpoint_x100 = 16'd40000 + 16'(code) * 16'd125;
      2'b01: setpoint_x100 = 16'd40000 + 16'(code) * 16'd250;
      2'b10: setpoint_x100 = 16'd40000 + 16'(code) * 16'd500;
      default: setpoint_x100 = 16'(17'd80000 + 17'(code) * 17'd1000
        - 17'd65536);
    endcase
  endfunction : setpoint_x100

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_setpoint_code <= 8'h00;
      setpoint_millivolt_x100 <= 16'h0000;
      spread_clock_enable <= 1'b0;
      switching_enable <= 1'b0;
      forced_pwm_active <= 1'b0;
      output_discharge_enable <= 1'b0;
      hiccup_enable <= 1'b0;
      setpoint_slew_select <= 2'b00;
      voltage_range_select <= 2'b00;
      softstart_time_select <= 2'b00;
      single_mode <= 1'b0;
      en_pulldown_enable <= 1'b1;
      sync_clock_out_enable <= 1'b1;
      power_good_pin_o <= 1'b0;
      power_good_pin_oe <= 1'b0;
      link.sda_dev_o <= 1'b1;
      link.sda_dev_oe <= 1'b0;
    end else begin
      output_setpoint_code <= setpoint_ff;
      setpoint_millivolt_x100 <= setpoint_x100(setpoint_ff, cfg_b_ff[3:2]);
      spread_clock_enable <= cfg_a_ff[`BIT_SPREAD];
      switching_enable <= cfg_a_ff[`BIT_SWITCH];
      forced_pwm_active <= cfg_a_ff[`BIT_FPWM] | mode_sync_ff[1];
      output_discharge_enable <= cfg_a_ff[`BIT_DISCH];
      hiccup_enable <= cfg_a_ff[`BIT_HICCUP];
      setpoint_slew_select <= cfg_a_ff[1:0];
      voltage_range_select <= cfg_b_ff[3:2];
      softstart_time_select <= cfg_b_ff[1:0];
      single_mode <= cfg_c_ff[`BIT_SINGLE];
      en_pulldown_enable <= !cfg_c_ff[`BIT_SINGLE];
      sync_clock_out_enable <= !cfg_c_ff[`BIT_SINGLE];
      power_good_pin_o <= 1'b0;
      power_good_pin_oe <= !win_sync_ff[1] &&
        !(cfg_c_ff[`BIT_PG_BLANK] && dvs_sync_ff[1]);
      link.sda_dev_o <= 1'b0;
      link.sda_dev_oe <= drive_low_ff && active_ff;
    end
  end
endmodule : conv_cfg_device

// >>> verilog/conv_cfg_host.sv
// Controller end: APB command registers driving two-wire transfers
`timescale 1ns/1ps
`include "conv_cfg_defines.svh"
module conv_cfg_host
  import conv_cfg_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link
  conv_link_if.host link
);
  // Command word: [15] go, [8] read, [7:0] register offset
  host_state_t state_ff;
  logic [7:0] div_ff, ofs_ff, wdata_ff, rdata_ff, tx_ff;
  logic [1:0] phase_ff, byte_idx_ff;
  logic [3:0] bit_ff;
  logic rd_ff, busy_ff, nack_ff, restart_ff;
  logic [1:0] sda_sync_ff;
  wire tick = (div_ff == `LINK_HALF_DIV - 8'd1);
  wire apb_wr = psel && penable && pwrite;
  wire go = apb_wr && paddr == `APB_REG_CMD && pwdata[15] && !busy_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_sync_ff <= 2'b11;
    end else begin
      sda_sync_ff <= {sda_sync_ff[0], link.sda};
    end
  end

  // APB answers with zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      wdata_ff <= 8'h00;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (apb_wr && paddr == `APB_REG_WDATA) begin
        wdata_ff <= pwdata[7:0];
      end
      unique case (paddr)
        `APB_REG_WDATA: prdata <= {24'h0, wdata_ff};
        `APB_REG_RDATA: prdata <= {24'h0, rdata_ff};
        `APB_REG_STATUS: prdata <= {30'h0, nack_ff, busy_ff};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Ofs not limited to defined registers; any offset is sent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= S_IDLE;
      div_ff <= 8'h00;
      phase_ff <= 2'b00;
      bit_ff <= 4'h0;
      byte_idx_ff <= 2'b00;
      ofs_ff <= 8'h00;
      rdata_ff <= 8'h00;
      tx_ff <= 8'h00;
      rd_ff <= 1'b0;
      busy_ff <= 1'b0;
      nack_ff <= 1'b0;
      restart_ff <= 1'b0;
      link.scl_o <= 1'b1;
      link.scl_oe <= 1'b0;
      link.sda_host_o <= 1'b1;
      link.sda_host_oe <= 1'b0;
    end else begin
      div_ff <= tick ? 8'h00 : div_ff + 8'h01;
      unique case (state_ff)
        S_IDLE: begin
          link.scl_oe <= 1'b0;
          link.sda_host_oe <= 1'b0;
          if (go) begin
            busy_ff <= 1'b1;
            nack_ff <= 1'b0;
            rd_ff <= pwdata[8];
            ofs_ff <= pwdata[7:0];
            byte_idx_ff <= 2'b00;
            restart_ff <= 1'b0;
            state_ff <= S_START;
            phase_ff <= 2'b00;
          end
        end
        S_START: if (tick) begin
          phase_ff <= phase_ff + 2'b01;
          if (phase_ff == 2'b00) begin
            link.sda_host_oe <= 1'b1;
            link.sda_host_o <= 1'b0;
          end else begin
            link.scl_oe <= 1'b1;
            link.scl_o <= 1'b0;
            tx_ff <= {`TARGET_ADDR, restart_ff};
            bit_ff <= 4'h0;
            phase_ff <= 2'b00;
            state_ff <= S_BYTE;
          end
        end
        S_BYTE, S_RBYTE, S_ACK: if (tick) begin
          phase_ff <= phase_ff + 2'b01;
          unique case (phase_ff)
            2'b00: begin
              link.sda_host_oe <= 1'b1;
              link.sda_host_o <= state_ff == S_BYTE ? tx_ff[7] :
                (state_ff == S_ACK && byte_idx_ff == 2'b11) ? 1'b1 :
                (state_ff == S_ACK ? 1'b1 : 1'b1);
            end
            2'b01: link.scl_oe <= 1'b0;
            2'b10: begin
              if (state_ff == S_RBYTE) begin
                rdata_ff <= {rdata_ff[6:0], sda_sync_ff[1]};
              end else if (state_ff == S_ACK && sda_sync_ff[1] &&
                           byte_idx_ff != 2'b11) begin
                nack_ff <= 1'b1;
              end
            end
            default: begin
              link.scl_oe <= 1'b1;
              link.scl_o <= 1'b0;
              if (state_ff != S_ACK) begin
                tx_ff <= {tx_ff[6:0], 1'b0};
                bit_ff <= bit_ff + 4'h1;
                if (bit_ff == 4'h7) begin
                  state_ff <= S_ACK;
                end
              end else begin
                bit_ff <= 4'h0;
                byte_idx_ff <= byte_idx_ff + 2'b01;
                if (nack_ff || byte_idx_ff == 2'b11 ||
                    (byte_idx_ff == 2'b10 && !rd_ff)) begin
                  // Pinned so the stop is never taken for a restart
                  byte_idx_ff <= 2'b11;
                  state_ff <= S_STOP;
                end else if (byte_idx_ff == 2'b00) begin
                  tx_ff <= restart_ff ? 8'h00 : ofs_ff;
                  state_ff <= restart_ff ? S_RBYTE : S_BYTE;
                  byte_idx_ff <= restart_ff ? 2'b11 : 2'b01;
                end else if (byte_idx_ff == 2'b01 && rd_ff) begin
                  restart_ff <= 1'b1;
                  byte_idx_ff <= 2'b00;
                  link.sda_host_o <= 1'b1;
                  state_ff <= S_STOP;
                end else if (byte_idx_ff == 2'b01) begin
                  tx_ff <= wdata_ff;
                  state_ff <= S_BYTE;
                end else begin
                  byte_idx_ff <= 2'b11;
                  state_ff <= S_ACK;
                end
              end
            end
          endcase
        end
        S_STOP: if (tick) begin
          phase_ff <= phase_ff + 2'b01;
          unique case (phase_ff)
            2'b00: begin
              link.sda_host_oe <= 1'b1;
              link.sda_host_o <= restart_ff && byte_idx_ff == 2'b00;
            end
            2'b01: link.scl_oe <= 1'b0;
            default: begin
              link.sda_host_oe <= 1'b0;
              phase_ff <= 2'b00;
              state_ff <= (restart_ff && byte_idx_ff == 2'b00 && !nack_ff) ?
                S_START : S_DONE;
              byte_idx_ff <= 2'b00;
            end
          endcase
        end
        S_DONE: begin
          busy_ff <= 1'b0;
          state_ff <= S_IDLE;
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end
endmodule : conv_cfg_host

// >>> verification/conv_link_monitor.sv
// Link checker between controller end and converter end
`timescale 1ns/1ps
module conv_link_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link wires
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_host_o,
  input wire logic sda_host_oe,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_dev_pulls_low: assert property (
    sda_dev_oe |-> !sda_dev_o) else $error("device drove data high");
  a_quiet_after_reset: assert property (
    $rose(presetn) |-> !sda_dev_oe ##1 !sda_dev_oe)
    else $error("device drove data right after reset");
  a_dev_release_bound: assert property (
    $rose(sda_dev_oe) |-> ##[1:300] !sda_dev_oe)
    else $error("device held data line too long");
  // Sync latency is short of a clock half, so moves land in the low phase
  a_dev_moves_low: assert property (
    $changed(sda_dev_oe) |-> !scl) else $error("device moved data in high");
  a_ack_spans_high: assert property (
    sda_dev_oe && $rose(scl) |-> sda_dev_oe [*4])
    else $error("acknowledge released early");
  a_free_at_start: assert property (
    scl && $past(scl) && $fell(sda) |-> !sda_dev_oe)
    else $error("device driving at start");
  a_free_at_stop: assert property (
    scl && $past(scl) && $rose(sda) |-> !sda_dev_oe [*2])
    else $error("device driving after stop");
  a_scl_low_span: assert property (
    $fell(scl) |-> !scl [*3] ##[1:40] scl)
    else $error("clock low phase out of range");
  c_ack: cover property ($rose(sda_dev_oe));
  c_start: cover property (scl && $past(scl) && $fell(sda));
  c_stop: cover property (scl && $past(scl) && $rose(sda));
endmodule : conv_link_monitor

// >>> verification/converter_config_registers_bench.sv
// Self-checking bench joining controller and converter ends
`timescale 1ns/1ps
`include "conv_cfg_defines.svh"
module converter_config_registers_bench
  import conv_cfg_pkg::*;
;
  typedef struct {string name; byte_t val;} exp_note_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, chk_en = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr;
  logic strap = 1'b1, mode = 1'b0, win_ok = 1'b1, transit = 1'b0;
  logic [5:0] events = 6'h00;
  logic [7:0] sp_code;
  logic [15:0] sp_mv;
  logic spread, sw_en, fpwm, disch, hic, single, en_pd, sync_en;
  logic good_o, good_oe;
  logic [1:0] slew, rng, sst;
  exp_note_t exp_q[$];
  int fails = 0, checks_done = 0, cycles = 0;
  conv_link_if link_i ();
  conv_cfg_host u_conv_cfg_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_i));
  conv_cfg_device u_conv_cfg_device (.pclk(pclk), .presetn(presetn),
    .link(link_i), .start_voltage_strap_pin(strap), .mode_sync_pin(mode),
    .pg_window_ok(win_ok), .dvs_active_in(transit), .fault_events(events),
    .output_setpoint_code(sp_code), .setpoint_millivolt_x100(sp_mv),
    .spread_clock_enable(spread), .switching_enable(sw_en),
    .forced_pwm_active(fpwm), .output_discharge_enable(disch),
    .hiccup_enable(hic), .setpoint_slew_select(slew),
    .voltage_range_select(rng), .softstart_time_select(sst),
    .single_mode(single), .en_pulldown_enable(en_pd),
    .sync_clock_out_enable(sync_en), .power_good_pin_o(good_o),
    .power_good_pin_oe(good_oe));
  conv_link_monitor u_conv_link_monitor (.pclk(pclk), .presetn(presetn),
    .scl_o(link_i.scl_o), .scl_oe(link_i.scl_oe),
    .sda_host_o(link_i.sda_host_o), .sda_host_oe(link_i.sda_host_oe),
    .sda_dev_o(link_i.sda_dev_o), .sda_dev_oe(link_i.sda_dev_oe),
    .scl(link_i.scl), .sda(link_i.sda));
  always #20 pclk = ~pclk;
  task automatic check(input string nm, input logic [15:0] seen,
    input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  // One edge idle first, so psel never toggles twice in a step
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d, input logic chk);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    chk_en <= chk;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    chk_en <= 1'b0;
  endtask : apb
  task automatic wait_idle();
    do apb(1'b0, `APB_REG_STATUS, 32'h0, 1'b0); while (q[0] !== 1'b0);
    check("nack", {15'h0, q[1]}, 16'h0000);
  endtask : wait_idle
  task automatic lwrite(input byte_t ofs, input byte_t d);
    apb(1'b1, `APB_REG_WDATA, {24'h0, d}, 1'b0);
    apb(1'b1, `APB_REG_CMD, {16'h0, 8'h80, ofs}, 1'b0);
    wait_idle();
  endtask : lwrite
  task automatic lread(input byte_t ofs, input string nm, input byte_t e);
    apb(1'b1, `APB_REG_CMD, {16'h0, 8'h81, ofs}, 1'b0);
    wait_idle();
    exp_q.push_back('{nm, e});
    apb(1'b0, `APB_REG_RDATA, 32'h0, 1'b1);
  endtask : lread
  task automatic defaults();
    lread(`OFS_CFG_A, "cfg_a", `RST_CFG_A);
    lread(`OFS_CFG_B, "cfg_b", `RST_CFG_B);
    lread(`OFS_CFG_C, "cfg_c", `RST_CFG_C);
    lread(`OFS_FLAGS, "flags", `RST_FLAGS);
  endtask : defaults
  task automatic do_reset(input logic s);
    presetn <= 1'b0;
    strap <= s;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask : do_reset
  function automatic logic [15:0] mv(input byte_t c, input logic [1:0] r);
    int v;
    v = (r == 2'b11) ? 80000 + c * 1000 : 40000 + c * (125 << r);
    return v[15:0];
  endfunction : mv
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      check("pslverr", {15'h0000, pslverr}, 16'h0000);
    end
    if (psel && penable && pready === 1'b1 && !pwrite && chk_en &&
        exp_q.size() > 0) begin
      check(exp_q[0].name, {8'h00, prdata[7:0]}, {8'h00, exp_q[0].val});
      void'(exp_q.pop_front());
    end
  end
  // Ceiling sized for roughly a hundred and fifty read transfers on the link
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 90000) begin
      fails++;
      report_and_stop();
    end
  end
  initial begin
    int i, r, v, e;
    e = $urandom(24);
    do_reset(1'b1);
    lread(`OFS_SETPOINT, "setpoint", `SETPOINT_STRAP_HIGH);
    defaults();
    check("pins", {spread, sw_en, disch, hic, single, en_pd, sync_en, slew,
      rng, sst, 3'b000}, 16'h6748);
    for (i = 0; i < 3; i++)
      lread(8'h05 + 8'($urandom_range(250)), "unmapped", 8'h00);
    $display("test defaults done");
    for (i = 0; i < 4; i++) begin
      v = ($urandom & 32'h7C) | i;
      mode <= i[0];
      lwrite(`OFS_CFG_A, 8'(v));
      lread(`OFS_CFG_A, "cfg_a", 8'(v));
      check("ctl", {9'h000, spread, sw_en, fpwm, disch, hic, slew},
        {9'h000, v[6:5], v[4] | i[0], v[3:0]});
    end
    $display("test control done");
    v = $urandom_range(255);
    lwrite(`OFS_SETPOINT, 8'(v));
    lread(`OFS_SETPOINT, "setpoint", 8'(v));
    check("code", {8'h00, sp_code}, {8'h00, 8'(v)});
    for (r = 0; r < 4; r++) begin
      lwrite(`OFS_CFG_B, 8'hF0 | 8'(r * 5));
      lread(`OFS_CFG_B, "cfg_b", 8'(r * 5));
      check("range", {12'h000, rng, sst}, 16'(r * 5));
      check("millivolt", sp_mv, mv(8'(v), 2'(r)));
    end
    $display("test range done");
    for (r = 0; r < 2; r++) begin
      lwrite(`OFS_CFG_C, 8'hFC | 8'(r * 3));
      lread(`OFS_CFG_C, "cfg_c", 8'(r * 3));
      check("single", {13'h0000, single, en_pd, sync_en},
        (r != 0) ? 16'h0004 : 16'h0003);
      for (i = 0; i < 4; i++) begin
        win_ok <= i[0];
        transit <= i[1];
        repeat (6) @(posedge pclk);
        check("power_good", {14'h0000, good_o, good_oe},
          {15'h0000, !i[0] && !(r != 0 && i[1] != 0)});
      end
    end
    $display("test single done");
    e = $urandom_range(63, 1);
    events <= 6'(e);
    @(posedge pclk);
    events <= 6'h00;
    lread(`OFS_FLAGS, "flags", 8'(e));
    lread(`OFS_FLAGS, "flags", 8'h00);
    $display("test flags done");
    lwrite(`OFS_CFG_A, 8'hBF);
    defaults();
    lread(`OFS_SETPOINT, "setpoint", `SETPOINT_STRAP_HIGH);
    $display("test soft reset done");
    // Reset lands in the middle of a transfer
    apb(1'b1, `APB_REG_WDATA, 32'h55, 1'b0);
    apb(1'b1, `APB_REG_CMD, 32'h8001, 1'b0);
    repeat (150) @(posedge pclk);
    do_reset(1'b0);
    lread(`OFS_SETPOINT, "setpoint", `SETPOINT_STRAP_LOW);
    defaults();
    $display("test second reset done");
    report_and_stop();
  end
endmodule : converter_config_registers_bench
